// ===== design/can_mode_pkg.sv
package can_mode_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h0C;
  localparam logic [7:0] ADDR_TIMER = 8'h10;
  localparam logic [7:0] ADDR_BITRATE = 8'h14;

  // ----------------------------------------
  // Command codes and field positions
  // ----------------------------------------
  localparam logic [2:0] CMD_INIT = 3'h1;
  localparam logic [2:0] CMD_BITRATE = 3'h2;
  localparam logic [2:0] CMD_START = 3'h3;
  localparam logic [2:0] CMD_STOP = 3'h4;
  localparam logic [2:0] CMD_SLEEP = 3'h5;
  localparam logic [2:0] CMD_WAKEUP = 3'h6;
  localparam int CFG_HW_SLEEP_BIT = 0;
  localparam int CFG_DET_BIT = 1;
  localparam int CFG_REINIT_BIT = 2;
  localparam int CFG_TIMEOUT_LSB = 8;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [31:0] CONFIG_RESET = 32'h0000_1003;
  localparam logic [31:0] BITRATE_STATIC = 32'h0000_0001;
  localparam int CLK_MHZ = 100;
  localparam int HW_SETTLE_NS = 80;
  localparam int HW_SETTLE_CYCLES = (HW_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_DIV = 4;

  typedef enum logic [2:0] {
    st_not_initialized_state,
    st_stopped,
    st_started,
    st_sleep
  } ctrl_state_t;
endpackage

// ===== design/mode_settle.sv
`timescale 1ns/1ps
// Models the hardware delay before a mode request shows in its status flag
module mode_settle
  import can_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic target,
  output logic flag
);
  logic [7:0] count;
  wire settled = (count == 8'(HW_SETTLE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      flag <= 1'b0;
    end else if (target == flag) begin
      count <= 8'h00;
    end else if (settled) begin
      count <= 8'h00;
      flag <= target;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule

// ===== design/can_mode_seq.sv
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module can_mode_seq
  import can_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_off_pin,
  input wire logic bus_wake_pin,
  output logic bus_enable,
  output logic hw_sleep,
  output logic tx_cancel,
  output logic mode_change_indication,
  output logic bus_off_notification,
  output logic wakeup_notification
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] boff_sync;
  logic [1:0] wake_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boff_sync <= 2'b00;
      wake_sync <= 2'b00;
    end else begin
      boff_sync <= {boff_sync[0], bus_off_pin};
      wake_sync <= {wake_sync[0], bus_wake_pin};
    end
  end
  wire bus_off_lvl = boff_sync[1];
  wire bus_wake_lvl = wake_sync[1];

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  ctrl_state_t state;
  ctrl_state_t pend_mode;
  logic initialized;
  logic [31:0] config_reg;
  logic [31:0] bitrate_reg;
  logic logical_sleep;
  logic pending;
  logic busy;
  logic run_req;
  logic sleep_req;
  logic err_transition;
  logic err_refused;
  logic err_timeout;
  logic ev_indication;
  logic ev_bus_off;
  logic ev_wakeup;
  logic [15:0] free_count;
  logic [15:0] deadline;
  logic [1:0] tick_div;
  logic run_flag;
  logic sleep_flag;
  logic bus_off_seen;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire hit_cmd = (paddr == ADDR_COMMAND);
  wire hit_cfg = (paddr == ADDR_CONFIG);
  wire hit_sts = (paddr == ADDR_STATUS);
  wire hit_evt = (paddr == ADDR_EVENTS);
  wire hit_tmr = (paddr == ADDR_TIMER);
  wire hit_br = (paddr == ADDR_BITRATE);
  wire mapped = hit_cmd | hit_cfg | hit_sts | hit_evt | hit_tmr | hit_br;
  wire [2:0] cmd = pwdata[2:0];
  wire cmd_wr = wr && hit_cmd && !busy;
  wire det_on = config_reg[CFG_DET_BIT];
  wire hw_sleep_ok = config_reg[CFG_HW_SLEEP_BIT];
  wire reinit = config_reg[CFG_REINIT_BIT];
  wire [15:0] timeout = config_reg[CFG_TIMEOUT_LSB +: 16];

  wire do_init = cmd_wr && (cmd == CMD_INIT);
  wire do_br = cmd_wr && (cmd == CMD_BITRATE);
  wire do_start = cmd_wr && (cmd == CMD_START);
  wire do_stop = cmd_wr && (cmd == CMD_STOP);
  wire do_sleep = cmd_wr && (cmd == CMD_SLEEP);
  wire do_wake = cmd_wr && (cmd == CMD_WAKEUP);

  wire bad_init = initialized || (state != st_not_initialized_state);
  wire bad_br = reinit && (state != st_stopped);
  wire bad_start = (state != st_stopped);
  wire bad_stop = (state != st_started) && (state != st_stopped);
  wire bad_sleep = (state != st_stopped) && (state != st_sleep);
  wire bad_wake = (state != st_sleep) && (state != st_stopped);
  // Transition checks gate only with detection on; off, request goes ahead as is; the bit-rate check gates always
  wire inv_init = det_on && bad_init;
  wire inv_start = det_on && bad_start;
  wire inv_stop = det_on && bad_stop;
  wire inv_sleep = det_on && bad_sleep;
  wire inv_wake = det_on && bad_wake;
  wire raise_inv = (do_init && inv_init) || (do_start && inv_start) || (do_stop && inv_stop)
    || (do_sleep && inv_sleep) || (do_wake && inv_wake) || (do_br && bad_br && det_on);

  // ----------------------------------------
  // Accepted requests
  // ----------------------------------------
  wire ok_init = do_init && !inv_init;
  wire ok_br = do_br && !bad_br;
  wire ok_start = do_start && !inv_start;
  wire ok_stop = do_stop && !inv_stop;
  wire ok_sleep = do_sleep && !inv_sleep;
  wire ok_wake = do_wake && !inv_wake;
  wire ok_mode = ok_start || ok_stop || ok_sleep || ok_wake;

  wire mode_done = pending && (run_flag == run_req) && (sleep_flag == sleep_req);
  wire time_up = busy && (free_count == deadline);
  wire hw_bus_off = bus_off_lvl && (state == st_started) && !bus_off_seen;
  wire hw_wake = bus_wake_lvl && (state == st_sleep) && hw_sleep_ok;

  // Sticky errors sit above busy, so one write clears them together
  wire [31:0] status_word = {24'h000000, err_timeout, err_refused, err_transition, busy,
    logical_sleep, initialized, state[1:0]};
  wire [31:0] event_word = {29'h0, ev_wakeup, ev_bus_off, ev_indication};
  wire [31:0] read_mux = hit_cfg ? config_reg : hit_sts ? status_word : hit_evt ? event_word :
    hit_tmr ? {16'h0, free_count} : hit_br ? bitrate_reg : 32'h0000_0000;

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= read_mux;
    end
  end

  // ----------------------------------------
  // Free-running counter and tick divider
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 2'b00;
      free_count <= 16'h0000;
    end else begin
      tick_div <= tick_div + 2'b01;
      if (tick_div == 2'(TICK_DIV - 1)) begin
        free_count <= free_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Configuration and bit-rate registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= CONFIG_RESET;
      bitrate_reg <= 32'h0000_0000;
    end else begin
      if (wr && hit_cfg) begin
        config_reg <= pwdata;
      end
      if (ok_init) begin
        bitrate_reg <= BITRATE_STATIC;
      end
      if (ok_br) begin
        bitrate_reg <= BITRATE_STATIC;
      end
    end
  end

  // ----------------------------------------
  // Controller state sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_not_initialized_state;
      pend_mode <= st_not_initialized_state;
      initialized <= 1'b0;
      logical_sleep <= 1'b0;
      pending <= 1'b0;
      busy <= 1'b0;
      run_req <= 1'b0;
      sleep_req <= 1'b0;
      deadline <= 16'h0000;
      bus_off_seen <= 1'b0;
    end else begin
      if (!bus_off_lvl) begin
        bus_off_seen <= 1'b0;
      end
      // Timeout frees the command port; the request stays pending
      if (time_up) begin
        busy <= 1'b0;
      end
      if (mode_done) begin
        pending <= 1'b0;
        busy <= 1'b0;
        state <= pend_mode;
      end
      // Bus-off and wake-up outrank any same-cycle request
      if (hw_bus_off) begin
        state <= st_stopped;
        run_req <= 1'b0;
        pending <= 1'b0;
        busy <= 1'b0;
        bus_off_seen <= 1'b1;
      end else if (hw_wake) begin
        state <= st_stopped;
        sleep_req <= 1'b0;
        pending <= 1'b0;
        busy <= 1'b0;
      end else if (ok_init) begin
        state <= st_stopped;
        initialized <= 1'b1;
      end else if (ok_br && reinit) begin
        run_req <= 1'b0;
      end else if (ok_mode) begin
        busy <= 1'b1;
        pending <= 1'b1;
        deadline <= free_count + timeout;
        if (do_start) begin
          run_req <= 1'b1;
          pend_mode <= st_started;
        end else if (do_stop) begin
          run_req <= 1'b0;
          pend_mode <= st_stopped;
        end else if (do_sleep) begin
          pend_mode <= st_sleep;
          if (hw_sleep_ok) begin
            sleep_req <= 1'b1;
          end else begin
            logical_sleep <= 1'b1;
          end
        end else begin
          pend_mode <= st_stopped;
          sleep_req <= 1'b0;
          logical_sleep <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Sticky errors and events, set beats clear
  // ----------------------------------------
  wire clr_evt = wr && hit_evt;
  wire clr_sts = wr && hit_sts;
  wire clr_transition = clr_sts && pwdata[5];
  wire clr_refused = clr_sts && pwdata[6];
  wire clr_timeout = clr_sts && pwdata[7];
  wire clr_indication = clr_evt && pwdata[0];
  wire clr_bus_off = clr_evt && pwdata[1];
  wire clr_wakeup = clr_evt && pwdata[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_transition <= 1'b0;
      err_refused <= 1'b0;
      err_timeout <= 1'b0;
      ev_indication <= 1'b0;
      ev_bus_off <= 1'b0;
      ev_wakeup <= 1'b0;
    end else begin
      err_transition <= raise_inv || (err_transition && !clr_transition);
      err_refused <= (do_br && bad_br) || (err_refused && !clr_refused);
      err_timeout <= (time_up && pending && !mode_done) || (err_timeout && !clr_timeout);
      ev_indication <= mode_done || (ev_indication && !clr_indication);
      ev_bus_off <= hw_bus_off || (ev_bus_off && !clr_bus_off);
      ev_wakeup <= hw_wake || (ev_wakeup && !clr_wakeup);
    end
  end

  // ----------------------------------------
  // Hardware mode flags and outputs
  // ----------------------------------------
  mode_settle run_settle (
    .pclk(pclk),
    .presetn(presetn),
    .target(run_req && !hw_bus_off),
    .flag(run_flag)
  );
  mode_settle sleep_settle (
    .pclk(pclk),
    .presetn(presetn),
    .target(sleep_req && !hw_wake),
    .flag(sleep_flag)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_enable <= 1'b0;
      hw_sleep <= 1'b0;
      tx_cancel <= 1'b0;
      mode_change_indication <= 1'b0;
      bus_off_notification <= 1'b0;
      wakeup_notification <= 1'b0;
    end else begin
      // Off the bus unless running; no acks or error frames when stopped
      // Frames queued before the flag settles may be lost
      bus_enable <= run_flag && run_req && !logical_sleep && !bus_off_lvl;
      hw_sleep <= sleep_flag;
      // Only pending frames cancel; a frame on the wire may still finish
      tx_cancel <= ok_stop || hw_bus_off;
      mode_change_indication <= mode_done;
      bus_off_notification <= hw_bus_off;
      wakeup_notification <= hw_wake;
    end
  end
endmodule

// ===== tb/can_mode_assertions.sv
`timescale 1ns/1ps
module can_mode_assertions
  import can_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic bus_off_pin,
  input wire logic bus_wake_pin,
  input wire logic bus_enable,
  input wire logic hw_sleep,
  input wire logic tx_cancel,
  input wire logic mode_change_indication,
  input wire logic bus_off_notification,
  input wire logic wakeup_notification
);
  // ----------------------------------------
  // Cycles since last command write
  // ----------------------------------------
  logic cmd_wr;
  logic [7:0] since;
  assign cmd_wr = psel && penable && pready && pwrite && paddr == ADDR_COMMAND;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since <= 8'hFF;
    end else if (cmd_wr) begin
      since <= 8'h00;
    end else if (since != 8'hFF) begin
      since <= since + 8'h01;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_join_by_cmd: assert property ($rose(bus_enable) |-> since < 8'h40)
    else $error("bus joined without a command");
  a_sleep_by_cmd: assert property ($rose(hw_sleep) |-> since < 8'h40)
    else $error("sleep entered without a command");
  a_ind_by_cmd: assert property (mode_change_indication |-> since < 8'h40)
    else $error("indication without a command");
  a_sleep_off_bus: assert property (hw_sleep |-> !bus_enable)
    else $error("on bus while asleep");
  a_busoff_cancel: assert property ($rose(bus_off_pin) && bus_enable |-> ##[1:8] tx_cancel)
    else $error("no cancel after bus-off");
  a_busoff_quiet: assert property (bus_off_notification |-> !bus_enable)
    else $error("still on bus at bus-off notice");
  a_wake_notify: assert property ($rose(bus_wake_pin) && hw_sleep |-> ##[2:12] wakeup_notification)
    else $error("no wake-up notice");
  a_stop_cancel: assert property (cmd_wr && pwdata[2:0] == CMD_STOP && bus_enable |-> ##[1:40] tx_cancel)
    else $error("no cancel on stop");
endmodule

// ===== tb/can_bus_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side network: bus-off and wake activity
// ----------------------------------------
module can_bus_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic off_req,
  input wire logic wake_req,
  input wire logic [3:0] hold,
  output logic bus_off_pin,
  output logic bus_wake_pin
);
  logic [3:0] off_cnt;
  logic [3:0] wake_cnt;
  // Sends no frames, so nothing waits on early transmits
  assign bus_off_pin = off_cnt != 4'h0;
  assign bus_wake_pin = wake_cnt != 4'h0;
  // Held several cycles so the synchroniser sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_cnt <= 4'h0;
      wake_cnt <= 4'h0;
    end else begin
      off_cnt <= off_req ? hold : off_cnt - {3'h0, off_cnt != 4'h0};
      wake_cnt <= wake_req ? hold : wake_cnt - {3'h0, wake_cnt != 4'h0};
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import can_mode_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, boff, bwake, bus_enable, hw_sleep;
  logic off_req = 1'b0;
  logic wake_req = 1'b0;
  logic [3:0] hold = 4'h2;
  logic [31:0] rdat;
  logic [64:0] q;
  logic [64:0] expq[$];
  int failures = 0;
  int n_checks = 0;
  int seed = 32'hA6894FF4;
  can_mode_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_off_pin(boff), .bus_wake_pin(bwake), .bus_enable(bus_enable), .hw_sleep(hw_sleep),
    .tx_cancel(), .mode_change_indication(), .bus_off_notification(), .wakeup_notification());
  can_bus_node node (.pclk(pclk), .presetn(presetn), .off_req(off_req), .wake_req(wake_req),
    .hold(hold), .bus_off_pin(boff), .bus_wake_pin(bwake));
  initial forever #5 pclk = ~pclk;
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] v, logic [31:0] m, logic e = 1'b0);
    expq.push_back({e, m, v});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic cmd(logic [2:0] c);
    wr(ADDR_COMMAND, {29'h0, c});
  endtask
  // Poll until settled and idle, then check
  task automatic sett(logic [1:0] s, logic [31:0] v, logic [31:0] m);
    int n = 0;
    do begin
      rd(ADDR_STATUS, 32'h0, 32'h0);
      n++;
    end while ((rdat[1:0] !== s || rdat[4] !== 1'b0) && n < 60);
    rd(ADDR_STATUS, {v[31:2], s}, m | 32'h13);
  endtask
  task automatic ck(logic a, logic e);
    n_checks++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH %0t level %b", $time, a);
    end
  endtask
  task automatic kick(logic w);
    @(posedge pclk);
    hold <= 4'h2 + 4'($random(seed) & 7);
    off_req <= !w;
    wake_req <= w;
    @(posedge pclk);
    off_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Read monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      q = expq.pop_front();
      n_checks++;
      if (((prdata ^ q[31:0]) & q[63:32]) !== 32'h0 || pslverr !== q[64]) begin
        failures++;
        $display("MISMATCH %0t read %h got %h", $time, paddr, prdata);
      end
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONFIG, CONFIG_RESET, 32'hFFFFFFFF);
    rd(ADDR_BITRATE, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_STATUS, 32'h0, 32'hFF);
    rd(8'h18, 32'h0, 32'h0, 1'b1);
    ck(bus_enable, 1'b0);
    cmd(CMD_START);
    sett(2'h0, 32'h20, 32'h20);
    wr(ADDR_STATUS, 32'hE0);
    cmd(CMD_INIT);
    sett(2'h1, 32'h04, 32'h24);
    rd(ADDR_BITRATE, BITRATE_STATIC, 32'hFFFFFFFF);
    cmd(CMD_INIT);
    sett(2'h1, 32'h20, 32'h20);
    wr(ADDR_STATUS, 32'hE0);
    cmd(CMD_START);
    sett(2'h2, 32'h0, 32'h20);
    ck(bus_enable, 1'b1);
    rd(ADDR_EVENTS, 32'h1, 32'h7);
    wr(ADDR_EVENTS, 32'h7);
    cmd(CMD_SLEEP);
    sett(2'h2, 32'h20, 32'h20);
    wr(ADDR_STATUS, 32'hE0);
    wr(ADDR_CONFIG, CONFIG_RESET | 32'h4);
    cmd(CMD_BITRATE);
    sett(2'h2, 32'h60, 32'h60);
    wr(ADDR_STATUS, 32'hE0);
    kick(1'b0);
    sett(2'h1, 32'h0, 32'h0);
    repeat (40) @(posedge pclk);
    sett(2'h1, 32'h0, 32'h0);
    rd(ADDR_EVENTS, 32'h2, 32'h7);
    wr(ADDR_EVENTS, 32'h7);
    cmd(CMD_BITRATE);
    sett(2'h1, 32'h0, 32'h60);
    ck(bus_enable, 1'b0);
    cmd(CMD_START);
    sett(2'h2, 32'h0, 32'h20);
    cmd(CMD_STOP);
    sett(2'h1, 32'h0, 32'h20);
    cmd(CMD_STOP);
    sett(2'h1, 32'h0, 32'h20);
    cmd(CMD_SLEEP);
    sett(2'h3, 32'h0, 32'h28);
    ck(hw_sleep, 1'b1);
    cmd(CMD_START);
    sett(2'h3, 32'h20, 32'h20);
    wr(ADDR_STATUS, 32'hE0);
    wr(ADDR_EVENTS, 32'h7);
    kick(1'b1);
    sett(2'h1, 32'h0, 32'h0);
    repeat (HW_SETTLE_CYCLES + 2) @(posedge pclk);
    ck(hw_sleep, 1'b0);
    rd(ADDR_EVENTS, 32'h4, 32'h5);
    wr(ADDR_EVENTS, 32'h7);
    // Random timeout, long enough for the flag to settle
    wr(ADDR_CONFIG, {8'h0, 8'h0 + 8'($random(seed) & 8'h7F), 8'h10, 8'h02});
    cmd(CMD_SLEEP);
    sett(2'h3, 32'h08, 32'h08);
    ck(hw_sleep, 1'b0);
    ck(bus_enable, 1'b0);
    cmd(CMD_STOP);
    sett(2'h3, 32'h28, 32'h28);
    wr(ADDR_STATUS, 32'hE0);
    cmd(CMD_WAKEUP);
    sett(2'h1, 32'h0, 32'h28);
    wr(ADDR_CONFIG, 32'h00001000);
    cmd(CMD_INIT);
    sett(2'h1, 32'h0, 32'h20);
    // One tick of timeout expires before the flag settles
    wr(ADDR_CONFIG, 32'h00000102);
    wr(ADDR_EVENTS, 32'h7);
    cmd(CMD_START);
    sett(2'h2, 32'h80, 32'h80);
    rd(ADDR_EVENTS, 32'h1, 32'h1);
    tally_and_finish;
  end
endmodule
bind can_mode_seq can_mode_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .bus_off_pin(bus_off_pin),
  .bus_wake_pin(bus_wake_pin), .bus_enable(bus_enable), .hw_sleep(hw_sleep), .tx_cancel(tx_cancel),
  .mode_change_indication(mode_change_indication), .bus_off_notification(bus_off_notification),
  .wakeup_notification(wakeup_notification));
